// ===== core/itc_trace_capture.sv
//----------------------------------------------------------------------
// Purpose: Real-time trace capture of an emulated 4-bit core
// Assumes: Core stream signals are on clk; one exec_valid per instruction
// Notes:   Registers over APB, zero wait states
//----------------------------------------------------------------------
`timescale 1ns/1ns
module itc_trace_capture #(
  parameter int DEPTH = itc_pkg::DEPTH,
  parameter int PTR_W = itc_pkg::PTR_W
) (
  // Clock and reset
  input  wire logic                     clk,
  input  wire logic                     sys_rst,
  // APB slave
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [7:0]               paddr,
  input  wire logic [31:0]              pwdata,
  output logic      [31:0]              prdata,
  output logic                          pready,
  output logic                          pslverr,
  // Execution stream
  input  wire logic                     exec_valid,
  input  wire logic [11:0]              exec_addr,
  input  wire itc_pkg::itc_core_t       core_state,
  input  wire logic                     go_start,
  input  wire logic [11:0]              go_addr,
  // Data write stream
  input  wire logic                     dm_we,
  input  wire logic [11:0]              dm_addr,
  input  wire logic [7:0]               dm_data,
  input  wire logic                     dm_wide,
  // Events
  output logic                          dm_match_break,
  output logic                          trace_wrap_pulse,
  output logic                          trace_active
);

  //--------------------------------------------------------------------
  // Functions
  //--------------------------------------------------------------------
  // Pointer step with wrap at the last location
  function automatic logic [PTR_W-1:0] ptr_step(input logic [PTR_W-1:0] p);
    ptr_step = (p == PTR_W'(DEPTH - 1)) ? '0 : PTR_W'(p + 1'b1);
  endfunction

  // Address equality, shared by trigger and data matching
  function automatic logic addr_hit(input logic [11:0] x, input logic [11:0] y);
    addr_hit = (x == y);
  endfunction

  //--------------------------------------------------------------------
  // State
  //--------------------------------------------------------------------
  logic [PTR_W-1:0]    ptr_reg;        // Trace write pointer
  logic                wrap_reg;       // Ring has wrapped at least once
  logic                trig_en_reg;    // Trigger mode selected
  logic                trig_act_reg;   // Between start and stop
  logic                skip_reg;       // Ignore first pass of start
  logic [1:0]          obj_sel_reg;    // Object set
  logic                large_reg;      // Large device mode
  logic [11:0]         tda_reg;        // Trace data address
  logic [11:0]         start_reg;      // Trace start address
  logic [11:0]         stop_reg;       // Trace stop address
  logic [7:0]          dmem_reg;       // Traced data value
  itc_pkg::itc_rec_t   snap_reg;       // Record staged one instruction back
  logic [PTR_W-1:0]    ridx_reg;       // Read index for software
  logic [11:0]         ten_addr_reg;   // Enable bit access address
  logic                ten_mem [4096]; // Per-address trace enable bits

  //--------------------------------------------------------------------
  // APB decode
  //--------------------------------------------------------------------
  logic                setup_w;        // Setup cycle of a transfer
  logic                wr_w;           // Write completes this edge
  logic                mapped_w;       // Address is one of ours
  logic [31:0]         rd_mux;         // Read value for this address
  logic [63:0]         ram_q;          // Record at read index
  logic                obj_wr_w;       // Accepted object change
  logic                clr_w;          // Any pointer clear source
  logic                store_w;        // Record is stored this edge
  logic                hit_start_w;    // Execution at start address
  logic                hit_stop_w;     // Execution at stop address
  logic                dm_hit_w;       // Data write to traced address
  logic [7:0]          obj_w;          // Selected object field
  logic [1:0]          flags_w;        // Bank flags for set zero
  itc_pkg::itc_rec_t   rec_w;          // Record of this instruction

  always_comb begin
    setup_w  = psel && !penable;
    wr_w     = psel && penable && pready && pwrite;
    mapped_w = (paddr[1:0] == 2'h0) && (paddr <= itc_pkg::OFS_TEN);
  end

  // Read multiplexer
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (paddr)
      itc_pkg::OFS_CTRL: rd_mux = {27'h0, 1'b0, large_reg, obj_sel_reg, trig_en_reg};
      itc_pkg::OFS_TDA:  rd_mux = {20'h0, tda_reg};
      itc_pkg::OFS_TRIG: rd_mux = {4'h0, stop_reg, 4'h0, start_reg};
      itc_pkg::OFS_STAT: rd_mux = 32'({trig_act_reg, wrap_reg, 16'(ptr_reg)});
      itc_pkg::OFS_RIDX: rd_mux = 32'(ridx_reg);
      itc_pkg::OFS_RLO:  rd_mux = ram_q[31:0];
      itc_pkg::OFS_RHI:  rd_mux = ram_q[63:32];
      itc_pkg::OFS_TEN:  rd_mux = {15'h0, ten_mem[ten_addr_reg], 4'h0, ten_addr_reg};
      default:           rd_mux = 32'h0000_0000;
    endcase
  end

  // Answer in the access cycle right after setup
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= setup_w;
      pslverr <= setup_w && !mapped_w;
      if (setup_w) begin
        prdata <= pwrite ? 32'h0000_0000 : rd_mux;
      end
    end
  end

  //--------------------------------------------------------------------
  // Configuration registers
  //--------------------------------------------------------------------
  // Object change only counts when the code is legal and differs
  always_comb begin
    obj_wr_w = wr_w && (paddr == itc_pkg::OFS_CTRL)
               && (pwdata[itc_pkg::CTRL_OBJ +: 2] != 2'h3)
               && (pwdata[itc_pkg::CTRL_OBJ +: 2] != obj_sel_reg);
  end

  // Mode, object and size
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      obj_sel_reg <= itc_pkg::OBJ_BANK;
      trig_en_reg <= 1'b0;
      large_reg   <= 1'b0;
    end else if (wr_w && paddr == itc_pkg::OFS_CTRL) begin
      trig_en_reg <= pwdata[itc_pkg::CTRL_TRIG];
      large_reg   <= pwdata[itc_pkg::CTRL_BIG];
      if (obj_wr_w) begin
        obj_sel_reg <= pwdata[itc_pkg::CTRL_OBJ +: 2];
      end
    end
  end

  // Addresses; software keeps them in the legal range
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tda_reg   <= itc_pkg::TDA_RST;
      start_reg <= itc_pkg::TRIG_RST;
      stop_reg  <= itc_pkg::TRIG_RST;
    end else if (wr_w) begin
      if (paddr == itc_pkg::OFS_TDA) begin
        tda_reg <= pwdata[11:0];
      end
      // Cancelling the mode never touches these, so they survive
      if (paddr == itc_pkg::OFS_TRIG) begin
        start_reg <= pwdata[11:0];
        stop_reg  <= pwdata[itc_pkg::TRIG_STOP +: 12];
      end
    end
  end

  // Read index and enable bit access
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ridx_reg     <= '0;
      ten_addr_reg <= 12'h000;
      for (int i = 0; i < 4096; i++) begin
        ten_mem[i] <= 1'b0;
      end
    end else if (wr_w) begin
      if (paddr == itc_pkg::OFS_RIDX) begin
        ridx_reg <= pwdata[PTR_W-1:0];
      end
      if (paddr == itc_pkg::OFS_TEN) begin
        ten_addr_reg          <= pwdata[11:0];
        ten_mem[pwdata[11:0]] <= pwdata[itc_pkg::TEN_DATA];
      end
    end
  end

  //--------------------------------------------------------------------
  // Trace qualification
  //--------------------------------------------------------------------
  always_comb begin
    hit_start_w = exec_valid && addr_hit(exec_addr, start_reg) && !skip_reg;
    hit_stop_w  = exec_valid && addr_hit(exec_addr, stop_reg);
    if (!exec_valid) begin
      store_w = 1'b0;
    end else if (trig_en_reg) begin
      // Stop wins so its own instruction is never kept
      store_w = !hit_stop_w && (trig_act_reg || hit_start_w);
    end else begin
      store_w = ten_mem[exec_addr];
    end
  end

  // Run flag between start and stop
  always_ff @(posedge clk) begin
    if (sys_rst || !trig_en_reg) begin
      trig_act_reg <= 1'b0;
    end else if (hit_stop_w) begin
      trig_act_reg <= 1'b0;
    end else if (hit_start_w) begin
      trig_act_reg <= 1'b1;
    end
  end

  // A go at the start address must not fire on its first instruction
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      skip_reg <= 1'b0;
    end else if (go_start) begin
      skip_reg <= addr_hit(go_addr, start_reg);
    end else if (exec_valid && addr_hit(exec_addr, start_reg)) begin
      skip_reg <= 1'b0;
    end
  end

  //--------------------------------------------------------------------
  // Data memory tracing
  //--------------------------------------------------------------------
  always_comb begin
    dm_hit_w = dm_we && addr_hit(dm_addr, tda_reg);
  end

  // Narrow writes fill the upper nibble with ones
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      dmem_reg <= 8'h00;
    end else if (dm_hit_w) begin
      dmem_reg <= dm_wide ? dm_data : {itc_pkg::NIB_ONES, dm_data[3:0]};
    end
  end

  // Match break shares the same compare
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      dm_match_break <= 1'b0;
    end else begin
      dm_match_break <= dm_hit_w;
    end
  end

  //--------------------------------------------------------------------
  // Record assembly
  //--------------------------------------------------------------------
  itc_obj_select u_obj (
    .sel        (obj_sel_reg),
    .large_mode (large_reg),
    .core       (core_state),
    .obj        (obj_w),
    .bank_flags (flags_w)
  );

  always_comb begin
    rec_w            = '0;
    rec_w.ba         = {core_state.b, core_state.a};
    rec_w.hl         = {core_state.h, core_state.l};
    rec_w.carry      = core_state.carry;
    rec_w.sp         = core_state.sp;
    rec_w.dmem       = dmem_reg;
    rec_w.port_two   = core_state.port_two;
    rec_w.port_three = core_state.port_three;
    rec_w.obj        = obj_w;
    rec_w.bank_flags = flags_w;
  end

  // Values are staged at each instruction and written at the next
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      snap_reg <= '0;
    end else if (exec_valid) begin
      snap_reg <= rec_w;
    end
  end

  itc_trace_ram #(
    .W     (itc_pkg::REC_W),
    .DEPTH (DEPTH),
    .AW    (PTR_W)
  ) u_ram (
    .clk   (clk),
    .we    (store_w),
    .waddr (ptr_reg),
    .wdata (snap_reg),
    .raddr (ridx_reg),
    .rdata (ram_q)
  );

  //--------------------------------------------------------------------
  // Write pointer and wrap
  //--------------------------------------------------------------------
  always_comb begin
    clr_w = go_start || obj_wr_w
            || (wr_w && paddr == itc_pkg::OFS_CTRL && pwdata[itc_pkg::CTRL_CLR]);
  end

  // Clear wins over a store in the same cycle
  always_ff @(posedge clk) begin
    if (sys_rst || clr_w) begin
      ptr_reg  <= PTR_W'(itc_pkg::PTR_RST);
      wrap_reg <= 1'b0;
    end else if (store_w) begin
      ptr_reg <= ptr_step(ptr_reg);
      if (ptr_reg == PTR_W'(DEPTH - 1)) begin
        wrap_reg <= 1'b1;
      end
    end
  end

  // Event and status outputs
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      trace_wrap_pulse <= 1'b0;
      trace_active     <= 1'b0;
    end else begin
      trace_wrap_pulse <= store_w && !clr_w && (ptr_reg == PTR_W'(DEPTH - 1));
      trace_active     <= store_w;
    end
  end

  //--------------------------------------------------------------------
  // Assertions
  //--------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_store_plain;
    store_w && !clr_w && ptr_reg != PTR_W'(DEPTH - 1);
  endsequence

  sequence s_stop_pass;
    exec_valid && trig_en_reg && addr_hit(exec_addr, stop_reg);
  endsequence

  a_ptr_advance: assert property (
    s_store_plain |=> ptr_reg == PTR_W'($past(ptr_reg) + 1'b1))
    else $error("pointer did not advance after a store");

  a_ptr_wrap: assert property (
    (store_w && !clr_w && ptr_reg == PTR_W'(DEPTH - 1)) |=> (ptr_reg == '0) && wrap_reg
      && trace_wrap_pulse)
    else $error("pointer wrap not handled");

  a_ptr_clear: assert property (
    clr_w |=> (ptr_reg == '0) && !wrap_reg)
    else $error("pointer clear not applied");

  a_wrap_sticky: assert property (
    (wrap_reg && !clr_w) |=> wrap_reg)
    else $error("wrap flag dropped");

  a_dm_capture: assert property (
    (dm_hit_w && dm_wide) |=> dmem_reg == $past(dm_data))
    else $error("wide data write not captured");

  a_dm_nibble: assert property (
    (dm_hit_w && !dm_wide) |=> dmem_reg[7:4] == 4'hF && dmem_reg[3:0] == $past(dm_data[3:0]))
    else $error("narrow write nibble wrong");

  a_dm_skip: assert property (
    !dm_hit_w |=> $stable(dmem_reg))
    else $error("data field changed without a match");

  a_break_match: assert property (
    dm_hit_w |=> dm_match_break)
    else $error("match break not raised");

  a_break_quiet: assert property (
    !dm_hit_w |=> !dm_match_break)
    else $error("match break raised without a match");

  a_stop_pass: assert property (
    s_stop_pass |-> !store_w ##1 !trig_act_reg)
    else $error("stop instruction recorded or run not ended");

  a_addr_mode: assert property (
    (exec_valid && !trig_en_reg) |-> store_w == ten_mem[exec_addr])
    else $error("address mode store mismatch");

  a_skip_first: assert property (
    (skip_reg && trig_en_reg && !trig_act_reg && exec_valid
      && addr_hit(exec_addr, start_reg)) |-> !store_w)
    else $error("first pass of start address traced");

  a_skip_arm: assert property (
    (go_start && addr_hit(go_addr, start_reg)) |=> skip_reg)
    else $error("go at start address did not arm skip");

  a_obj_change: assert property (
    obj_wr_w |=> ptr_reg == '0 && obj_sel_reg != $past(obj_sel_reg))
    else $error("object change did not clear pointer");

  a_small_port: assert property (
    (!large_reg && obj_sel_reg != itc_pkg::OBJ_BANK) |-> obj_w[7:4] == 4'h0)
    else $error("port four captured in small mode");

  a_rst_defaults: assert property (
    $fell(sys_rst) |-> obj_sel_reg == itc_pkg::OBJ_BANK && !trig_en_reg)
    else $error("reset defaults wrong");

endmodule

// ===== core/itc_pkg.sv
//----------------------------------------------------------------------
// Purpose: Shared constants and carriers for the instruction trace capture
// Assumes: 4-bit core with 12-bit code and data addresses
// Notes:   Register map is word aligned on APB
//----------------------------------------------------------------------
package itc_pkg;

  //--------------------------------------------------------------------
  // Sizes and reset values
  //--------------------------------------------------------------------
  localparam int          REC_W     = 64;       // Record width
  localparam int          DEPTH     = 8192;     // Records in the ring
  localparam int          PTR_W     = 13;       // Pointer width
  localparam int          CA_W      = 12;       // Code and data address width
  localparam logic [12:0] PTR_RST   = 13'h0000; // Pointer after clear
  localparam logic [11:0] TDA_RST   = 12'h700;  // Trace data address after reset
  localparam logic [11:0] TRIG_RST  = 12'h000;  // Start and stop after reset
  localparam logic [3:0]  NIB_ONES  = 4'hF;     // Upper nibble of narrow writes

  //--------------------------------------------------------------------
  // Register offsets and field positions
  //--------------------------------------------------------------------
  localparam logic [7:0]  OFS_CTRL  = 8'h00;    // Mode, object, size, clear
  localparam logic [7:0]  OFS_TDA   = 8'h04;    // Trace data address
  localparam logic [7:0]  OFS_TRIG  = 8'h08;    // Start and stop address
  localparam logic [7:0]  OFS_STAT  = 8'h0C;    // Pointer and wrap state
  localparam logic [7:0]  OFS_RIDX  = 8'h10;    // Record read index
  localparam logic [7:0]  OFS_RLO   = 8'h14;    // Record bits 31..0
  localparam logic [7:0]  OFS_RHI   = 8'h18;    // Record bits 63..32
  localparam logic [7:0]  OFS_TEN   = 8'h1C;    // Trace enable bit access
  localparam int          CTRL_TRIG = 0;        // Trigger mode enable
  localparam int          CTRL_OBJ  = 1;        // Object select, two bits
  localparam int          CTRL_BIG  = 3;        // Large device mode
  localparam int          CTRL_CLR  = 4;        // Pointer clear strobe
  localparam int          TRIG_STOP = 16;       // Stop address position
  localparam int          STAT_WRAP = 16;       // Wrapped flag position
  localparam int          STAT_ACT  = 17;       // Trigger run flag position
  localparam int          TEN_DATA  = 16;       // Enable bit value position

  //--------------------------------------------------------------------
  // Object set encodings
  //--------------------------------------------------------------------
  localparam logic [1:0]  OBJ_BANK  = 2'h0;     // Bank flags and bank selects
  localparam logic [1:0]  OBJ_P4P0  = 2'h1;     // Port four and port zero
  localparam logic [1:0]  OBJ_P4P1  = 2'h2;     // Port four and port one

  // Live state of the emulated core
  typedef struct packed {
    logic [3:0] b, a, h, l;
    logic       carry;
    logic [7:0] sp;
    logic [3:0] port_two, port_three, port_four, port_zero, port_one;
    logic       first_bank_flag, second_bank_flag;
    logic [3:0] bank_select_low, bank_select_high;
  } itc_core_t;

  // One trace record, 64 bits
  typedef struct packed {
    logic [12:0] spare;
    logic [1:0]  bank_flags;
    logic [7:0]  obj;
    logic [3:0]  port_three, port_two;
    logic [7:0]  dmem;
    logic [7:0]  sp;
    logic        carry;
    logic [7:0]  hl;
    logic [7:0]  ba;
  } itc_rec_t;

endpackage

// ===== core/itc_trace_ram.sv
//----------------------------------------------------------------------
// Purpose: Ring trace memory, one write and one registered read port
// Assumes: Write and read indices supplied by the capture logic
// Notes:   No reset on the array, contents are only trusted once written
//----------------------------------------------------------------------
`timescale 1ns/1ns
module itc_trace_ram #(
  parameter int W     = 64,
  parameter int DEPTH = 8192,
  parameter int AW    = 13
) (
  // Clock
  input  wire logic          clk,
  // Write port
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [W-1:0]  wdata,
  // Read port
  input  wire logic [AW-1:0] raddr,
  output logic      [W-1:0]  rdata
);

  logic [W-1:0] mem [DEPTH];  // Record storage

  // Write in ring order as the pointer dictates
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // Registered read, one cycle behind the index
  always_ff @(posedge clk) begin
    rdata <= mem[raddr];
  end

endmodule

// ===== core/itc_obj_select.sv
//----------------------------------------------------------------------
// Purpose: Builds the 8-bit object field of a trace record
// Assumes: Selection code already checked by the register logic
// Notes:   Pure combinational, no state
//----------------------------------------------------------------------
`timescale 1ns/1ns
module itc_obj_select (
  // Selection
  input  wire logic [1:0]       sel,
  input  wire logic             large_mode,
  // Core state
  input  wire itc_pkg::itc_core_t core,
  // Field out
  output logic      [7:0]       obj,
  output logic      [1:0]       bank_flags
);

  logic [3:0] p4_w;  // Port four, blanked in small mode

  // Small device has no port four worth capturing
  always_comb begin
    p4_w = large_mode ? core.port_four : 4'h0;
  end

  // Pick one of the three sets
  always_comb begin
    bank_flags = 2'h0;
    case (sel)
      itc_pkg::OBJ_BANK: begin
        obj        = {core.bank_select_high, core.bank_select_low};
        bank_flags = {core.second_bank_flag, core.first_bank_flag};
      end
      itc_pkg::OBJ_P4P0: obj = {p4_w, core.port_zero};
      itc_pkg::OBJ_P4P1: obj = {p4_w, core.port_one};
      default:           obj = 8'h00;
    endcase
  end

endmodule

// ===== verif/itc_core_model.sv
// Purpose: Emulated core, one instruction per cycle while run is high
// Assumes: Start address loaded a cycle before run
// Notes:   Only the accumulator pair follows the address
`timescale 1ns/1ns
module itc_core_model (
  // Control
  input  wire logic          clk,
  input  wire logic          run,
  input  wire logic          load,
  input  wire logic [11:0]   pc0,
  // Instruction stream
  output logic               exec_valid,
  output logic [11:0]        exec_addr,
  output itc_pkg::itc_core_t core_state
);
  //------------------------------------------------------------
  // Program counter and live state
  //------------------------------------------------------------
  logic [11:0] pc = 12'h000; // Next first-byte address
  initial {exec_valid, exec_addr, core_state} = '0;
  // State nibbles differ per step, so a missing delay shows
  always @(posedge clk) begin
    exec_valid <= run;
    pc <= load ? pc0 : pc + {11'h000, run};
    if (run) {exec_addr, core_state.b, core_state.a} <= {pc, pc[3:0], pc[7:4]};
  end
endmodule

// ===== verif/testbench.sv
// Purpose: Self-checking bench for instruction trace capture
// Assumes: Ring cut to 16 records so a wrap comes soon
// Notes:   APB waits have no timeout of their own; a hung one ends only at the cycle ceiling
`timescale 1ns/1ns
module testbench;
  //------------------------------------------------------------
  // Signals, design and core model
  //------------------------------------------------------------
  logic               clk = 1'b0, sys_rst, psel, penable, pwrite, pready, pslverr;
  logic               exec_valid, go_start, dm_we, dm_wide, run, load;
  logic               dm_match_break, trace_wrap_pulse, trace_active;
  logic [7:0]         paddr, dm_data;
  logic [11:0]        exec_addr, go_addr, dm_addr, pc0;
  logic [31:0]        pwdata, prdata, q;
  logic               se;
  int                 error_cnt, check_count, cycles, n_act, n_wrap;
  itc_pkg::itc_core_t core_state;
  itc_trace_capture #(.DEPTH(16), .PTR_W(4)) i_itc_trace_capture (.*);
  itc_core_model i_itc_core_model (.*);
  initial forever #5 clk = ~clk;
  // Ceiling far above the 130 or so cycles needed
  always @(posedge clk) begin
    cycles++;
    n_act += trace_active;
    n_wrap += trace_wrap_pulse;
    if (cycles == 3000) begin
      error_cnt++;
      close_out();
    end
  end
  task automatic close_out();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", s, exp, seen);
    end
  endtask
  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, d};
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    se = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] m, x, input string s);
    apb(1'b0, a, 32'h0);
    chk(s, q & m, x);
  endtask
  // Run n instructions from a; g also pulses go_start with go_addr at a
  task automatic exec(input logic g, input logic [11:0] a, input int n);
    @(posedge clk);
    {go_start, go_addr, load, pc0} <= {g, a, 1'b1, a};
    @(posedge clk);
    {go_start, load, run} <= 3'b001;
    repeat (n) @(posedge clk);
    run <= 1'b0;
  endtask
  // Data write, wide when w is set; break flag looked at in the next cycle
  task automatic dmw(input logic [11:0] a, input logic x, input logic w);
    @(posedge clk);
    {dm_we, dm_addr, dm_data, dm_wide} <= {1'b1, a, 8'h5A, w};
    @(posedge clk);
    dm_we <= 1'b0;
    @(negedge clk);
    chk("match break", {31'h0, dm_match_break}, {31'h0, x});
  endtask
  initial begin
    // Bus idle, core stopped, reset held
    {psel, penable, pwrite, paddr, pwdata, go_start, go_addr, dm_we, dm_addr} = '0;
    {dm_data, dm_wide, run, load, pc0, sys_rst} = 1'b1;
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    rdc(8'h00, '1, 32'h0, "ctrl");
    rdc(8'h20, '1, 32'h0, "unmapped");
    chk("slverr", {31'h0, se}, 32'h1);
    apb(1'b1, 8'h1C, 32'h0001_0003);
    exec(1'b1, 12'h000, 8);
    rdc(8'h0C, '1, 32'h1, "addr ptr");
    apb(1'b1, 8'h08, 32'h0005_0002);
    apb(1'b1, 8'h00, 32'h1);
    exec(1'b1, 12'h002, 6);
    exec(1'b0, 12'h000, 8);
    rdc(8'h0C, 32'h1FFFF, 32'h3, "trig ptr");
    apb(1'b1, 8'h00, 32'h4);
    rdc(8'h08, '1, 32'h0005_0002, "saved trig");
    rdc(8'h0C, '1, 32'h0, "obj clear");
    apb(1'b1, 8'h04, 32'h790);
    dmw(12'h791, 1'b0, 1'b0);
    dmw(12'h790, 1'b1, 1'b0);
    apb(1'b1, 8'h08, 32'h0FFF_0001);
    apb(1'b1, 8'h00, 32'h5);
    exec(1'b1, 12'h000, 3);
    apb(1'b1, 8'h10, 32'h1);
    rdc(8'h14, 32'hFE00_00FF, 32'hF400_0010, "rec lo");
    rdc(8'h18, 32'h1, 32'h1, "rec hi");
    exec(1'b0, 12'h003, 15);
    rdc(8'h0C, 32'h1FFFF, 32'h1_0001, "wrap");
    dmw(12'h790, 1'b1, 1'b1);
    exec(1'b0, 12'h020, 2);
    apb(1'b1, 8'h10, 32'h2);
    rdc(8'h14, 32'hFE00_00FF, 32'hB400_0002, "wide lo");
    rdc(8'h18, 32'h1, 32'h0, "wide hi");
    chk("stores", n_act, 32'h17);
    chk("wraps", n_wrap, 32'h1);
    close_out();
  end
endmodule
